// *** include/serial_port_defs.svh ***
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// register byte offsets
`define SPS_OFF_STATUS 8'h00
`define SPS_OFF_CONTROL 8'h04
`define SPS_OFF_DATA 8'h08
`define SPS_OFF_INT_STATUS 8'h0C
`define SPS_OFF_INT_CLEAR 8'h10
`define SPS_OFF_INT_ENABLE 8'h14

// status register field positions
`define SPS_RX_COUNT_HI 28
`define SPS_RX_COUNT_LO 24
`define SPS_TX_COUNT_HI 20
`define SPS_TX_COUNT_LO 16
`define SPS_BIT_FRAME_ERROR 12
`define SPS_BIT_ACTIVE 11
`define SPS_BIT_UNDERRUN 8
`define SPS_BIT_SHIFTER_EMPTY 7
`define SPS_BIT_OVERFLOW 6
`define SPS_BIT_RX_EMPTY 5
`define SPS_BIT_TX_EMPTY 3
`define SPS_BIT_TX_FULL 1
`define SPS_BIT_RX_FULL 0

// control register field positions
`define SPS_CTL_MODULE_ON 0
`define SPS_CTL_DEEP_FIFO 1
`define SPS_CTL_FRAMING 2
`define SPS_CTL_OVF_IGNORE 3
`define SPS_CTL_UR_IGNORE 4
`define SPS_CTL_WIDTH 5
`define SPS_CTL_RESET 5'h00

// interrupt event bit positions
`define SPS_EV_RX_WORD 0
`define SPS_EV_TX_LOAD 1
`define SPS_EV_OVERFLOW 2
`define SPS_EV_UNDERRUN 3
`define SPS_EV_FRAME_ERROR 4
`define SPS_EV_WIDTH 5

// fifo and word geometry
`define SPS_WORD_BITS 8
`define SPS_PTR_BITS 4
`define SPS_FIFO_DEPTH 16

`endif

// *** include/serial_port_pkg.sv ***
package serial_port_pkg;

    typedef enum logic [1:0] {
        RUN_OFF = 2'b00,
        RUN_ACTIVE = 2'b01,
        RUN_HALTED = 2'b10
    } run_state_t;

endpackage : serial_port_pkg

// *** src/link_shifter.sv ***
`timescale 1ns/10ps
`include "serial_port_defs.svh"

module link_shifter (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // link timing, already synchronised
    input wire logic i_active,
    input wire logic i_flush,
    input wire logic i_rise,
    input wire logic i_fall,
    input wire logic i_sdi,
    // word load from the transmit side
    input wire logic i_load,
    input wire logic [`SPS_WORD_BITS-1:0] i_load_data,
    // results
    output logic o_sdo,
    output logic o_rx_done,
    output logic [`SPS_WORD_BITS-1:0] o_rx_word,
    output logic o_empty,
    output logic o_mid_word,
    output logic o_word_start
);

    logic [`SPS_WORD_BITS-1:0] tx_sr;
    logic [`SPS_WORD_BITS-1:0] rx_sr;
    logic [2:0] bit_cnt;
    logic loaded;

    wire sample = i_active & i_rise;
    wire last_bit = sample & (bit_cnt == 3'h7);
    wire abort = i_flush | (~i_active & o_mid_word);

    assign o_sdo = tx_sr[`SPS_WORD_BITS-1];
    assign o_empty = ~loaded & (bit_cnt == 3'h0);
    assign o_mid_word = (bit_cnt != 3'h0);
    assign o_word_start = sample & (bit_cnt == 3'h0);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bit_cnt <= 3'h0;
            rx_sr <= 8'h00;
            o_rx_word <= 8'h00;
            o_rx_done <= 1'b0;
        end else begin
            o_rx_done <= last_bit;
            if (!i_active || i_flush) begin
                bit_cnt <= 3'h0;
            end else if (i_rise) begin
                bit_cnt <= 3'(bit_cnt + 3'h1);
            end
            if (sample) begin
                rx_sr <= {rx_sr[6:0], i_sdi};
            end
            if (last_bit) begin
                o_rx_word <= {rx_sr[6:0], i_sdi};
            end
        end
    end

    // once a word is shifted out only zeros follow until the next load
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_sr <= 8'h00;
            loaded <= 1'b0;
        end else if (abort) begin
            tx_sr <= 8'h00;
            loaded <= 1'b0;
        end else if (i_load) begin
            tx_sr <= i_load_data;
            loaded <= 1'b1;
        end else begin
            if (i_active && i_fall) begin
                tx_sr <= {tx_sr[6:0], 1'b0};
            end
            if (i_active && i_fall && bit_cnt == 3'h0) begin
                loaded <= 1'b0;
            end
        end
    end

endmodule : link_shifter

// *** src/serial_port_status_flags.sv ***
`timescale 1ns/10ps
`include "serial_port_defs.svh"

// Operation
// R1: rx fill count in bits 28 to 24
// R2: tx fill count in bits 20 to 16
// R3: frame error sticks until software clears
// R4: activity bit high during any transfer
// R5: underrun flag set, cleared by restart or zero
// R6: bit 7 shows shift register empty
// R7: overflow set when received word discarded
// R8: overflow cleared only by restart or zero
// R9: rx empty when read equals write pointer
// R10: tx empty set on load, cleared on write
// R11: standard mode tx full set by write
// R12: deep mode tx full at pointer plus one
// R13: standard mode rx full until software read
// R14: deep mode rx full at pointer plus one
// R15: unimplemented status bits read zero
// R16: overflow halts port unless ignored
// R17: underrun halts, or zeros sent if ignored
// R18: writing one to error flags changes nothing
module serial_port_status_flags (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // serial link, the peer drives clock and frame select
    input wire logic i_sck,
    input wire logic i_sdi,
    input wire logic i_ss_n,
    output logic o_sdo,
    output logic o_sdo_oe_n,
    // interrupt
    output logic o_irq
);

    // reset release
    logic rstn_meta;
    logic sys_rstn;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rstn_meta <= 1'b0;
            sys_rstn <= 1'b0;
        end else begin
            rstn_meta <= 1'b1;
            sys_rstn <= rstn_meta;
        end
    end

    // link pin synchronisers and edge detection
    logic [2:0] pins_sync;
    logic sck_prev;
    logic ss_n_prev;

    sync_two_flop #(
        .WIDTH(3)
    ) u_pin_sync (
        .i_clk(i_sys_clk),
        .i_rstn(sys_rstn),
        .i_async({~i_ss_n, i_sdi, i_sck}),
        .o_sync(pins_sync)
    );

    wire sck_s = pins_sync[0];
    wire sdi_s = pins_sync[1];
    wire ss_n_s = ~pins_sync[2];
    wire sck_rise = sck_s & ~sck_prev;
    wire sck_fall = ~sck_s & sck_prev;
    wire frame_end = ss_n_s & ~ss_n_prev;

    always_ff @(posedge i_sys_clk or negedge sys_rstn) begin
        if (!sys_rstn) begin
            sck_prev <= 1'b0;
            ss_n_prev <= 1'b1;
        end else begin
            sck_prev <= sck_s;
            ss_n_prev <= ss_n_s;
        end
    end

    // apb decode
    logic [`SPS_CTL_WIDTH-1:0] control;
    logic [`SPS_EV_WIDTH-1:0] int_status;
    logic [`SPS_EV_WIDTH-1:0] int_enable;
    logic [31:0] status_word;
    logic [31:0] read_mux;

    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable;
    wire hit_status = (i_paddr == `SPS_OFF_STATUS);
    wire hit_control = (i_paddr == `SPS_OFF_CONTROL);
    wire hit_data = (i_paddr == `SPS_OFF_DATA);
    wire hit_int_status = (i_paddr == `SPS_OFF_INT_STATUS);
    wire hit_int_clear = (i_paddr == `SPS_OFF_INT_CLEAR);
    wire hit_int_enable = (i_paddr == `SPS_OFF_INT_ENABLE);
    wire mapped = hit_status | hit_control | hit_data | hit_int_status | hit_int_clear | hit_int_enable;
    wire wr_status = access & i_pwrite & hit_status;
    wire wr_control = access & i_pwrite & hit_control;
    wire wr_data = access & i_pwrite & hit_data;
    wire rd_data = access & ~i_pwrite & hit_data;
    wire wr_int_clear = access & i_pwrite & hit_int_clear;
    wire wr_int_enable = access & i_pwrite & hit_int_enable;

    // every access completes in its first access cycle
    assign o_pready = 1'b1;
    assign o_pslverr = access & ~mapped;

    // control fields
    wire module_on = control[`SPS_CTL_MODULE_ON];
    wire deep_fifo_enable = control[`SPS_CTL_DEEP_FIFO];
    wire framing_enable = control[`SPS_CTL_FRAMING];
    wire overflow_ignore = control[`SPS_CTL_OVF_IGNORE];
    wire underrun_ignore = control[`SPS_CTL_UR_IGNORE];
    logic module_on_prev;
    wire restart = module_on & ~module_on_prev;

    always_ff @(posedge i_sys_clk or negedge sys_rstn) begin
        if (!sys_rstn) begin
            control <= `SPS_CTL_RESET;
            module_on_prev <= 1'b0;
        end else begin
            module_on_prev <= module_on;
            if (wr_control) begin
                control <= i_pwdata[`SPS_CTL_WIDTH-1:0];
            end
        end
    end

    // run state
    serial_port_pkg::run_state_t run_state;
    serial_port_pkg::run_state_t next_run_state;
    logic ovf_event;
    logic ur_event;
    logic fe_event;

    wire running = (run_state == serial_port_pkg::RUN_ACTIVE);
    wire link_active = running & ~ss_n_s;
    wire critical = (ovf_event & ~overflow_ignore) | (ur_event & ~underrun_ignore); // R16 R17

    always_comb begin
        next_run_state = run_state;
        case (run_state)
            serial_port_pkg::RUN_OFF: begin
                if (module_on) begin
                    next_run_state = serial_port_pkg::RUN_ACTIVE;
                end
            end
            serial_port_pkg::RUN_ACTIVE: begin
                if (!module_on) begin
                    next_run_state = serial_port_pkg::RUN_OFF;
                end else if (critical) begin
                    next_run_state = serial_port_pkg::RUN_HALTED; // R16 R17
                end
            end
            serial_port_pkg::RUN_HALTED: begin
                // only switching the module off and on again restarts it
                if (!module_on) begin
                    next_run_state = serial_port_pkg::RUN_OFF;
                end
            end
            default: begin
                next_run_state = serial_port_pkg::RUN_OFF;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge sys_rstn) begin
        if (!sys_rstn) begin
            run_state <= serial_port_pkg::RUN_OFF;
        end else begin
            run_state <= next_run_state;
        end
    end

    // transmit fifo, holds a single word in standard mode
    logic [`SPS_WORD_BITS-1:0] tx_mem [`SPS_FIFO_DEPTH];
    logic [`SPS_PTR_BITS-1:0] cpu_write_pointer;
    logic [`SPS_PTR_BITS-1:0] shifter_read_pointer;

    wire [`SPS_PTR_BITS-1:0] tx_used = `SPS_PTR_BITS'(cpu_write_pointer - shifter_read_pointer);
    wire [4:0] tx_fill_count = {1'b0, tx_used}; // R2
    wire tx_holding_empty_flag = (tx_used == 4'h0); // R10
    wire tx_deep_full = (`SPS_PTR_BITS'(cpu_write_pointer + 4'h1) == shifter_read_pointer); // R12
    wire tx_holding_full_flag = deep_fifo_enable ? tx_deep_full : ~tx_holding_empty_flag; // R11 R12
    wire tx_push = wr_data & ~tx_holding_full_flag & module_on;

    // receive fifo
    logic [`SPS_WORD_BITS-1:0] rx_mem [`SPS_FIFO_DEPTH];
    logic [`SPS_PTR_BITS-1:0] shifter_write_pointer;
    logic [`SPS_PTR_BITS-1:0] cpu_read_pointer;

    wire [`SPS_PTR_BITS-1:0] rx_used = `SPS_PTR_BITS'(shifter_write_pointer - cpu_read_pointer);
    wire [4:0] rx_fill_count = {1'b0, rx_used}; // R1
    wire rx_fifo_empty_flag = (cpu_read_pointer == shifter_write_pointer); // R9
    wire rx_deep_full = (`SPS_PTR_BITS'(shifter_write_pointer + 4'h1) == cpu_read_pointer); // R14
    wire rx_holding_full_flag = deep_fifo_enable ? rx_deep_full : ~rx_fifo_empty_flag; // R13 R14
    wire rx_pop = rd_data & ~rx_fifo_empty_flag;

    // shift engine
    logic shifter_empty_flag;
    logic mid_word;
    logic word_start;
    logic rx_done;
    logic [`SPS_WORD_BITS-1:0] rx_word;

    // while running, a word moves to the shifter as soon as it is free
    wire tx_pop = running & shifter_empty_flag & ~tx_holding_empty_flag; // R10 R11
    wire rx_push = rx_done & ~rx_holding_full_flag;

    link_shifter u_shifter (
        .i_clk(i_sys_clk),
        .i_rstn(sys_rstn),
        .i_active(link_active),
        .i_flush(~running),
        .i_rise(sck_rise),
        .i_fall(sck_fall),
        .i_sdi(sdi_s),
        .i_load(tx_pop),
        .i_load_data(tx_mem[shifter_read_pointer]),
        .o_sdo(o_sdo),
        .o_rx_done(rx_done),
        .o_rx_word(rx_word),
        .o_empty(shifter_empty_flag), // R6
        .o_mid_word(mid_word),
        .o_word_start(word_start)
    );

    // fifo pointers are cleared while the module is off
    always_ff @(posedge i_sys_clk or negedge sys_rstn) begin
        if (!sys_rstn) begin
            cpu_write_pointer <= 4'h0;
            shifter_read_pointer <= 4'h0;
            shifter_write_pointer <= 4'h0;
            cpu_read_pointer <= 4'h0;
        end else if (!module_on) begin
            cpu_write_pointer <= 4'h0;
            shifter_read_pointer <= 4'h0;
            shifter_write_pointer <= 4'h0;
            cpu_read_pointer <= 4'h0;
        end else begin
            if (tx_push) begin
                cpu_write_pointer <= `SPS_PTR_BITS'(cpu_write_pointer + 4'h1); // R10 R11
            end
            if (tx_pop) begin
                shifter_read_pointer <= `SPS_PTR_BITS'(shifter_read_pointer + 4'h1); // R10 R11
            end
            if (rx_push) begin
                shifter_write_pointer <= `SPS_PTR_BITS'(shifter_write_pointer + 4'h1); // R13
            end
            if (rx_pop) begin
                cpu_read_pointer <= `SPS_PTR_BITS'(cpu_read_pointer + 4'h1); // R13
            end
        end
    end

    // storage has no reset; pointers decide what is valid
    always_ff @(posedge i_sys_clk) begin
        if (tx_push) begin
            tx_mem[cpu_write_pointer] <= i_pwdata[`SPS_WORD_BITS-1:0];
        end
        if (rx_push) begin
            rx_mem[shifter_write_pointer] <= rx_word;
        end
    end

    // error events; a full receiver discards the new word and keeps the old
    assign ovf_event = rx_done & rx_holding_full_flag; // R7
    assign ur_event = framing_enable & word_start & shifter_empty_flag; // R5
    assign fe_event = framing_enable & running & frame_end & mid_word; // R3

    // sticky error flags; a set in the clearing cycle wins
    logic rx_overflow_flag;
    logic tx_underrun_flag;
    logic frame_error_flag;

    wire clr_ovf = (wr_status & ~i_pwdata[`SPS_BIT_OVERFLOW]) | restart; // R8 R18
    wire clr_ur = (wr_status & ~i_pwdata[`SPS_BIT_UNDERRUN]) | restart; // R5 R18
    wire clr_fe = wr_status & ~i_pwdata[`SPS_BIT_FRAME_ERROR]; // R3 R18

    always_ff @(posedge i_sys_clk or negedge sys_rstn) begin
        if (!sys_rstn) begin
            rx_overflow_flag <= 1'b0;
            tx_underrun_flag <= 1'b0;
            frame_error_flag <= 1'b0;
        end else begin
            rx_overflow_flag <= ovf_event | (rx_overflow_flag & ~clr_ovf); // R7 R8
            tx_underrun_flag <= ur_event | (tx_underrun_flag & ~clr_ur); // R5
            frame_error_flag <= fe_event | (frame_error_flag & ~clr_fe); // R3
        end
    end

    // activity covers an open frame while running and any word still in the shifter
    wire port_active_flag = link_active | ~shifter_empty_flag; // R4

    // status word, positions not listed stay zero
    always_comb begin
        status_word = 32'h0000_0000; // R15
        status_word[`SPS_RX_COUNT_HI:`SPS_RX_COUNT_LO] = rx_fill_count; // R1
        status_word[`SPS_TX_COUNT_HI:`SPS_TX_COUNT_LO] = tx_fill_count; // R2
        status_word[`SPS_BIT_FRAME_ERROR] = frame_error_flag; // R3
        status_word[`SPS_BIT_ACTIVE] = port_active_flag; // R4
        status_word[`SPS_BIT_UNDERRUN] = tx_underrun_flag; // R5
        status_word[`SPS_BIT_SHIFTER_EMPTY] = shifter_empty_flag; // R6
        status_word[`SPS_BIT_OVERFLOW] = rx_overflow_flag; // R7
        status_word[`SPS_BIT_RX_EMPTY] = rx_fifo_empty_flag; // R9
        status_word[`SPS_BIT_TX_EMPTY] = tx_holding_empty_flag; // R10
        status_word[`SPS_BIT_TX_FULL] = tx_holding_full_flag; // R11 R12
        status_word[`SPS_BIT_RX_FULL] = rx_holding_full_flag; // R13 R14
    end

    // interrupts
    logic [`SPS_EV_WIDTH-1:0] events;

    always_comb begin
        events = '0;
        events[`SPS_EV_RX_WORD] = rx_push;
        events[`SPS_EV_TX_LOAD] = tx_pop;
        events[`SPS_EV_OVERFLOW] = ovf_event;
        events[`SPS_EV_UNDERRUN] = ur_event;
        events[`SPS_EV_FRAME_ERROR] = fe_event;
    end

    wire [`SPS_EV_WIDTH-1:0] int_clear_mask = wr_int_clear ? i_pwdata[`SPS_EV_WIDTH-1:0] : '0;

    always_ff @(posedge i_sys_clk or negedge sys_rstn) begin
        if (!sys_rstn) begin
            int_status <= '0;
            int_enable <= '0;
            o_irq <= 1'b0;
        end else begin
            int_status <= events | (int_status & ~int_clear_mask);
            if (wr_int_enable) begin
                int_enable <= i_pwdata[`SPS_EV_WIDTH-1:0];
            end
            o_irq <= |((events | (int_status & ~int_clear_mask)) & int_enable);
        end
    end

    // read data is captured in setup and held through access
    always_comb begin
        case (i_paddr)
            `SPS_OFF_STATUS: read_mux = status_word;
            `SPS_OFF_CONTROL: read_mux = {27'h000_0000, control};
            `SPS_OFF_DATA: read_mux = {24'h00_0000, rx_mem[cpu_read_pointer]};
            `SPS_OFF_INT_STATUS: read_mux = {27'h000_0000, int_status};
            `SPS_OFF_INT_ENABLE: read_mux = {27'h000_0000, int_enable};
            default: read_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge sys_rstn) begin
        if (!sys_rstn) begin
            o_prdata <= 32'h0000_0000;
        end else if (setup && !i_pwrite) begin
            o_prdata <= (hit_data && rx_fifo_empty_flag) ? 32'h0000_0000 : read_mux;
        end
    end

    // data out is driven only while the peer selects us
    always_ff @(posedge i_sys_clk or negedge sys_rstn) begin
        if (!sys_rstn) begin
            o_sdo_oe_n <= 1'b1;
        end else begin
            o_sdo_oe_n <= ~link_active;
        end
    end

endmodule : serial_port_status_flags

// *** src/sync_two_flop.sv ***
`timescale 1ns/10ps

module sync_two_flop #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // asynchronous level in, synchronous level out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end

endmodule : sync_two_flop

// *** verification/serial_port_monitor.sv ***
`timescale 1ns/10ps
`include "serial_port_defs.svh"

module serial_port_monitor (
    // clock, reset and apb
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // link and interrupt
    input wire logic i_ss_n,
    input wire logic o_sdo_oe_n,
    input wire logic o_irq
);
    wire logic mapped;
    wire logic rd_setup;
    assign mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= `SPS_OFF_INT_ENABLE);
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_access;
        i_psel && i_penable;
    endsequence
    sequence s_mask_all;
        s_access ##0 (i_pwrite && i_paddr == `SPS_OFF_INT_ENABLE && i_pwdata[`SPS_EV_WIDTH-1:0] == 5'h00);
    endsequence
    a_ready_high: assert property (o_pready) else $error("pready low");
    a_err_unmapped: assert property (s_access ##0 !mapped |-> o_pslverr) else $error("no slverr");
    a_err_mapped: assert property (s_access ##0 mapped |-> !o_pslverr) else $error("stray slverr");
    a_err_idle: assert property (!(i_psel && i_penable) |-> !o_pslverr) else $error("slverr off access");
    a_rdata_hold: assert property (!rd_setup |=> $stable(o_prdata)) else $error("prdata moved");
    a_unmapped_zero: assert property (s_access ##0 (!mapped && !i_pwrite) |-> o_prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_oe_deselect: assert property (i_ss_n [*6] |-> o_sdo_oe_n) else $error("sdo driven unselected");
    a_irq_masked: assert property (s_mask_all |-> ##2 !o_irq) else $error("irq while masked");
endmodule : serial_port_monitor

bind serial_port_status_flags serial_port_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ss_n(i_ss_n),
    .o_sdo_oe_n(o_sdo_oe_n), .o_irq(o_irq));

// *** verification/spi_peer_model.sv ***
`timescale 1ns/10ps

module spi_peer_model (
    // link toward the port
    output logic o_sck,
    output logic o_ss_n,
    output logic o_sdi,
    input wire logic i_sdo
);
    initial begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
        o_sdi = 1'b0;
    end
    // mode 0 master; clock idles low; a short count cuts the word
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        #37 o_ss_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            o_sdi = tx[7-i];
            #100 o_sck = 1'b1;
            rx = {rx[6:0], i_sdo};
            #100 o_sck = 1'b0;
        end
        #100 o_ss_n = 1'b1;
        // released data line shows no stale bit
        o_sdi = ~o_sdi;
        #200;
    endtask : xfer
endmodule : spi_peer_model

// *** verification/test_serial_port_status_flags.sv ***
`timescale 1ns/10ps
`include "serial_port_defs.svh"

module test_serial_port_status_flags;
    logic i_sys_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_sdo, o_sdo_oe_n, o_irq, perr;
    wire logic sck, ss_n, sdi;
    int err_count = 0;
    int checks_done = 0;
    int seed = 9214;
    int rx_q[$];
    logic [31:0] q;
    logic [7:0] w, w2, b, got;

    always #12.5 i_sys_clk = ~i_sys_clk;

    serial_port_status_flags uut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sck(sck), .i_sdi(sdi),
        .i_ss_n(ss_n), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_irq(o_irq));
    spi_peer_model peer (.o_sck(sck), .o_ss_n(ss_n), .o_sdi(sdi), .i_sdo(o_sdo));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            conclude();
        end
        q = o_prdata;
        perr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, q & m, e);
    endtask : rd

    task automatic st(input logic [31:0] m, input logic [31:0] e, input string n);
        rd(`SPS_OFF_STATUS, m, e, n);
    endtask : st

    task automatic irq_is(input logic e);
        repeat (3) @(posedge i_sys_clk);
        chk("irq", {31'h0, o_irq}, {31'h0, e});
    endtask : irq_is

    initial begin
        #2_500_000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        st(32'hFFFF_FFFF, 32'h0000_00A8, "status reset");
        rd(`SPS_OFF_CONTROL, 32'hFFFF_FFFF, 32'h0000_0000, "control reset");
        rd(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
        chk("slverr", {31'h0, perr}, 32'h0000_0001);
        $display("test reset done");
        apb(1'b1, `SPS_OFF_CONTROL, 32'h0000_0003);
        for (int i = 0; i < 3; i++) begin
            w = 8'($random(seed));
            b = 8'($random(seed));
            apb(1'b1, `SPS_OFF_DATA, {24'h0, w});
            repeat (4) @(posedge i_sys_clk);
            st(32'h0000_0880, 32'h0000_0800, "loaded busy");
            peer.xfer(b, 8, got);
            rx_q.push_back(b);
            chk("peer rx", {24'h0, got}, {24'h0, w});
            repeat (8) @(posedge i_sys_clk);
        end
        st(32'h1F00_08A0, {3'b0, 5'(rx_q.size()), 24'h00_0080}, "rx count");
        while (rx_q.size() > 0) rd(`SPS_OFF_DATA, 32'h0000_00FF, 32'(rx_q.pop_front()), "rx data");
        st(32'h1F00_0020, 32'h0000_0020, "rx drained");
        $display("test deep transfer done");
        for (int i = 0; i < 16; i++) begin
            b = 8'($random(seed));
            if (i < 15) rx_q.push_back(b);
            peer.xfer(b, 8, got);
            repeat (8) @(posedge i_sys_clk);
            if (i == 14) st(32'h1F00_0061, 32'h0F00_0001, "rx full");
        end
        st(32'h1F00_0061, 32'h0F00_0041, "overflow");
        apb(1'b1, `SPS_OFF_INT_ENABLE, 32'h0000_0004);
        irq_is(1'b1);
        apb(1'b1, `SPS_OFF_INT_ENABLE, 32'h0000_0000);
        irq_is(1'b0);
        apb(1'b1, `SPS_OFF_INT_ENABLE, 32'h0000_0004);
        irq_is(1'b1);
        apb(1'b1, `SPS_OFF_INT_CLEAR, 32'h0000_0004);
        irq_is(1'b0);
        apb(1'b1, `SPS_OFF_STATUS, 32'hFFFF_FFFF);
        st(32'h1F00_0041, 32'h0F00_0041, "write ones");
        apb(1'b1, `SPS_OFF_STATUS, 32'h0000_0000);
        st(32'h1F00_0041, 32'h0F00_0001, "write zero");
        rd(`SPS_OFF_DATA, 32'h0000_00FF, 32'(rx_q.pop_front()), "rx data");
        peer.xfer(8'($random(seed)), 8, got);
        repeat (8) @(posedge i_sys_clk);
        st(32'h1F00_0041, 32'h0E00_0000, "halted");
        apb(1'b1, `SPS_OFF_CONTROL, 32'h0000_0000);
        apb(1'b1, `SPS_OFF_CONTROL, 32'h0000_0003);
        rx_q.delete();
        st(32'hFFFF_FFFF, 32'h0000_00A8, "restart");
        for (int i = 0; i < 17; i++) apb(1'b1, `SPS_OFF_DATA, 32'($random(seed)));
        st(32'h001F_000A, 32'h000F_0002, "tx full");
        $display("test deep buffers done");
        apb(1'b1, `SPS_OFF_CONTROL, 32'h0000_0000);
        apb(1'b1, `SPS_OFF_CONTROL, 32'h0000_0001);
        w = 8'($random(seed));
        w2 = 8'($random(seed));
        b = 8'($random(seed));
        apb(1'b1, `SPS_OFF_DATA, {24'h0, w});
        apb(1'b1, `SPS_OFF_DATA, {24'h0, w2});
        st(32'h0000_000B, 32'h0000_0002, "std tx full");
        peer.xfer(b, 8, got);
        repeat (8) @(posedge i_sys_clk);
        chk("peer rx", {24'h0, got}, {24'h0, w});
        st(32'h0000_000B, 32'h0000_0009, "std moved");
        rd(`SPS_OFF_DATA, 32'h0000_00FF, {24'h0, b}, "std rx data");
        st(32'h0000_0001, 32'h0000_0000, "std read");
        $display("test standard mode done");
        apb(1'b1, `SPS_OFF_CONTROL, 32'h0000_0000);
        apb(1'b1, `SPS_OFF_CONTROL, 32'h0000_0015);
        peer.xfer(8'($random(seed)), 4, got);
        repeat (8) @(posedge i_sys_clk);
        st(32'h0000_1100, 32'h0000_1100, "underrun frame error");
        apb(1'b1, `SPS_OFF_STATUS, 32'h0000_1140);
        st(32'h0000_1100, 32'h0000_1100, "ones keep");
        apb(1'b1, `SPS_OFF_STATUS, 32'h0000_0000);
        st(32'h0000_1100, 32'h0000_0000, "zero clears");
        peer.xfer(8'($random(seed)), 8, got);
        chk("zeros sent", {24'h0, got}, 32'h0000_0000);
        repeat (8) @(posedge i_sys_clk);
        st(32'h0000_1100, 32'h0000_0100, "underrun again");
        apb(1'b1, `SPS_OFF_CONTROL, 32'h0000_0000);
        apb(1'b1, `SPS_OFF_CONTROL, 32'h0000_0015);
        st(32'h0000_0100, 32'h0000_0000, "restart clears");
        $display("test framing done");
        conclude();
    end
endmodule : test_serial_port_status_flags
